// ==== verilog/ipc_pkg.sv ====
// Constants and types shared by the idle and power-down controller
package ipc_pkg;
    // Timing: the core clock is the oscillator, one period per cycle
    localparam int          OSC_PERIOD_NS    = 10;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          OSC_PER_MCYCLE   = 12;
    localparam int          RST_HOLD_MCYCLES = 2;
    localparam int          RST_HOLD_PERIODS = RST_HOLD_MCYCLES * OSC_PER_MCYCLE;
    localparam int          WAKE_DLY_PERIODS = 1536;
    localparam int          MCYCLE_CLKS      =
        (OSC_PER_MCYCLE * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RST_HOLD_CLKS    =
        (RST_HOLD_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_DLY_CLKS    =
        (WAKE_DLY_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          MC_W             = 4;
    localparam int          RH_W             = 5;
    localparam int          WD_W             = 11;

    // Special function register map
    localparam logic [7:0]  PMC_ADDR         = 8'h87;
    localparam logic [7:0]  PMC_RESET        = 8'h00;
    localparam logic [7:0]  PMC_RW_MASK      = 8'h8f;
    localparam int          BAUD_DOUBLE_BIT  = 7;
    localparam int          USER_FLAG_HI_BIT = 3;
    localparam int          USER_FLAG_LO_BIT = 2;
    localparam int          PD_REQ_BIT       = 1;
    localparam int          IDLE_REQ_BIT     = 0;

    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    localparam logic [7:0]  BYTE_ONES        = 8'hff;

    typedef enum logic [1:0] {
        IPC_RUN  = 2'b00,
        IPC_IDLE = 2'b01,
        IPC_PD   = 2'b10,
        IPC_WAKE = 2'b11
    } ipc_state_t;
endpackage

// ==== verilog/ipc_sync.sv ====
// Two flip-flop synchroniser for pin inputs
module ipc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            stage1 <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// ==== verilog/ipc_counter.sv ====
// Up counter with clear and wrap at a terminal value
module ipc_counter #(
    parameter int W    = 4,
    parameter int LAST = 11
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_ce,
    input  wire logic         i_clr,
    input  wire logic         i_en,
    output logic      [W-1:0] o_count,
    output logic              o_last
);
    localparam logic [W-1:0] LAST_V = W'(LAST);
    localparam logic [W-1:0] ONE_V  = W'(1);

    assign o_last = (o_count == LAST_V);

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || (i_ce && i_clr)) begin
            o_count <= '0;
        end else if (i_ce && i_en) begin
            o_count <= o_last ? '0 : o_count + ONE_V;
        end
    end
endmodule

// ==== verilog/ipc_power_ctrl.sv ====
// Idle and power-down mode controller with its mode control register
//
// Overview of operation
// - Machine cycle is twelve oscillator periods
// - Mode register at 87H, byte access only
// - Bit7 baud double, 6-4 reserved, 1 pd, 0 idle
// - Bits 3 and 2 are free user flags
// - Only the power-down request bit enters power-down
// - Oscillator stops for whole power-down
// - Power-down keeps RAM, registers and port latches
// - Power-down drives both strobes low
// - Port-1 wake, then 1536 period clock hold
// - Reset wake skips the start-up delay
// - Idle gates CPU clock only
// - Idle keeps CPU state and all registers
// - Idle holds port states, strobes driven high
// - Enabled interrupt clears mode bits, ends idle
// - Reset of two machine cycles ends idle
// - Reset restores registers, leaves RAM alone
// - Power-down restores port-2 latch, ones driven strong
// - External memory: port 0 floats, port 2 varies
// - Baud double resets to 0, doubles rate
module ipc_power_ctrl (
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    // Special function register port
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic [7:0]        i_sfr_wdata,
    input  wire logic              i_sfr_wr,
    input  wire logic              i_sfr_rd,
    input  wire logic              i_sfr_bitop,
    output logic                   o_sfr_hit,
    output logic      [7:0]        o_sfr_rdata,
    // External pins
    input  wire logic              i_reset_pin,
    input  wire logic [7:0]        i_port1_wake_interrupts,
    // Interrupt controller
    input  wire logic [7:0]        i_wake_enable,
    input  wire logic              i_irq_active,
    // CPU side
    input  wire logic              i_ext_mem,
    input  wire logic              i_ale_cpu,
    input  wire logic              i_program_fetch_strobe_cpu,
    input  wire logic [7:0]        i_p0_bus_out,
    input  wire logic              i_p0_bus_oe,
    input  wire logic [7:0]        i_p2_addr,
    input  wire logic [7:0]        i_p0_latch,
    input  wire logic [7:0]        i_p1_latch,
    input  wire logic [7:0]        i_port_two_latch,
    input  wire logic [7:0]        i_p3_latch,
    // Clock gates and mode outputs
    output logic                   o_osc_run,
    output logic                   o_cpu_clk_en,
    output logic                   o_periph_clk_en,
    output logic                   o_cpu_reset,
    output logic                   o_mcycle_tick,
    output logic                   o_baud_double,
    output logic                   o_ale,
    output logic                   o_program_fetch_strobe,
    output logic      [7:0]        o_p0_out,
    output logic      [7:0]        o_p0_oe,
    output logic      [7:0]        o_p1_out,
    output logic      [7:0]        o_p2_out,
    output logic      [7:0]        o_p2_oe,
    output logic      [7:0]        o_p3_out
);
    import ipc_pkg::*;

    ipc_state_t      st;
    ipc_state_t      next_st;
    logic [7:0]      power_mode_control;
    logic [7:0]      next_pmc;
    logic [7:0]      held_addr;
    logic            int_rst;
    logic            next_int_rst;
    logic            rst_sync;
    logic [7:0]      wake_sync;
    logic [MC_W-1:0] mc_cnt;
    logic            mc_last;
    logic [RH_W-1:0] rh_cnt;
    logic            rh_last;
    logic [WD_W-1:0] wd_cnt;
    logic            wd_last;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    ipc_sync #(.W(1)) u_rst_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_async    (i_reset_pin),
        .o_sync     (rst_sync)
    );

    ipc_sync #(.W(8)) u_wake_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_async    (i_port1_wake_interrupts),
        .o_sync     (wake_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire rst_all   = !i_resetn || int_rst;
    wire in_run    = (st == IPC_RUN);
    wire in_idle   = (st == IPC_IDLE);
    wire in_pd     = (st == IPC_PD);
    wire in_wake   = (st == IPC_WAKE);
    wire osc_alive = !in_pd && !in_wake;
    wire pd_req    = power_mode_control[PD_REQ_BIT];
    wire idle_req  = power_mode_control[IDLE_REQ_BIT];
    wire wake_any  = |(wake_sync & i_wake_enable);
    wire idle_exit = in_idle && i_irq_active;
    wire wake_done = in_wake && wd_last;
    wire addr_hit  = (i_sfr_addr == PMC_ADDR);
    // Not bit addressable: a bit operation aimed here is ignored
    wire sw_write  = i_sfr_wr && addr_hit && !i_sfr_bitop;
    wire enter_pd  = in_run && pd_req;
    wire enter_idl = in_run && idle_req && !pd_req;

    ////////////////////////////////////////////////////////////////////////
    // Counters

    // Machine cycle divider clears to zero while the oscillator is stopped
    ipc_counter #(.W(MC_W), .LAST(MCYCLE_CLKS - 1)) u_mcycle (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_clr      (!osc_alive),
        .i_en       (osc_alive),
        .o_count    (mc_cnt),
        .o_last     (mc_last)
    );

    // Reset pin hold time, two machine cycles of periods
    ipc_counter #(.W(RH_W), .LAST(RST_HOLD_CLKS - 1)) u_rst_hold (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_clr      (!rst_sync || int_rst),
        .i_en       (rst_sync),
        .o_count    (rh_cnt),
        .o_last     (rh_last)
    );

    // Start-up delay, zero on entry to the wake state
    ipc_counter #(.W(WD_W), .LAST(WAKE_DLY_CLKS - 1)) u_wake_dly (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_clr      (!in_wake || int_rst),
        .i_en       (in_wake),
        .o_count    (wd_cnt),
        .o_last     (wd_last)
    );

    assign o_mcycle_tick = mc_last && osc_alive;

    // Reset pin held long enough becomes the internal reset.
    // The oscillator must be stable before the pin drops; no wait here.
    assign next_int_rst = rst_sync && (int_rst || rh_last);

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine

    always_comb begin
        next_st = st;
        unique case (st)
            IPC_RUN: begin
                if (enter_pd) begin
                    next_st = IPC_PD;
                end else if (enter_idl) begin
                    next_st = IPC_IDLE;
                end
            end
            IPC_IDLE: begin
                if (idle_exit) begin
                    next_st = IPC_RUN;
                end
            end
            IPC_PD: begin
                if (wake_any) begin
                    next_st = IPC_WAKE;
                end
            end
            IPC_WAKE: begin
                if (wd_last) begin
                    next_st = IPC_RUN;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode control register

    always_comb begin
        next_pmc = power_mode_control;
        if (sw_write) begin
            next_pmc = i_sfr_wdata & PMC_RW_MASK;
        end
        // Only the mode bits clear so user flags still tell idle apart
        if (idle_exit || wake_done) begin
            next_pmc[PD_REQ_BIT]   = 1'b0;
            next_pmc[IDLE_REQ_BIT] = 1'b0;
        end
    end

    // RAM is outside this block and is never touched by reset
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            power_mode_control <= PMC_RESET;
            st                 <= IPC_RUN;
        end else if (i_ce) begin
            power_mode_control <= next_pmc;
            st                 <= next_st;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            int_rst <= 1'b0;
        end else if (i_ce) begin
            int_rst <= next_int_rst;
        end
    end

    // Idle keeps the address that port 2 showed at entry
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            held_addr <= BYTE_ZERO;
        end else if (i_ce && enter_idl) begin
            held_addr <= i_p2_addr;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_sfr_rdata <= BYTE_ZERO;
        end else if (i_ce && i_sfr_rd && addr_hit) begin
            o_sfr_rdata <= power_mode_control & PMC_RW_MASK;
        end
    end

    assign o_sfr_hit     = addr_hit && !i_sfr_bitop;
    assign o_baud_double = power_mode_control[BAUD_DOUBLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Clock gates, strobes and pins

    // The CPU gets one more cycle after its request write, then halts
    assign o_osc_run       = osc_alive;
    assign o_cpu_clk_en    = in_run;
    assign o_periph_clk_en = in_run || in_idle;
    assign o_cpu_reset     = rst_all;

    assign o_ale = in_pd || in_wake ? 1'b0 :
                   in_idle ? 1'b1 : i_ale_cpu;
    assign o_program_fetch_strobe = in_pd || in_wake ? 1'b0 :
                                    in_idle ? 1'b1 : i_program_fetch_strobe_cpu;

    wire       bus_p0  = i_ext_mem && in_run && i_p0_bus_oe;
    wire [7:0] p0_open = ~i_p0_latch;

    // Port 0 floats in either low-power mode under external memory
    assign o_p0_out = bus_p0 ? i_p0_bus_out : BYTE_ZERO;
    assign o_p0_oe  = bus_p0 ? BYTE_ONES :
                      (i_ext_mem && !in_run) ? BYTE_ZERO :
                      (i_ext_mem ? BYTE_ZERO : p0_open);
    assign o_p1_out = i_p1_latch;
    assign o_p3_out = i_p3_latch;

    // Port 2 shows the latch again in power-down, ones driven strong
    assign o_p2_out = (!i_ext_mem || in_pd || in_wake) ?
                      i_port_two_latch :
                      (in_idle ? held_addr : i_p2_addr);
    assign o_p2_oe  = BYTE_ONES;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    a_pd_strobes_low: assert property (
        in_pd |-> !o_ale && !o_program_fetch_strobe)
        else $error("strobes not low in power-down");

    a_idle_strobes_high: assert property (
        in_idle |-> o_ale && o_program_fetch_strobe)
        else $error("strobes not high in idle");

    a_pd_osc_stop: assert property (
        in_pd |-> !o_osc_run && !o_periph_clk_en)
        else $error("oscillator running in power-down");

    a_idle_cpu_gate: assert property (
        in_idle |-> !o_cpu_clk_en && o_periph_clk_en)
        else $error("idle clock gating wrong");

    a_pd_only_sw: assert property (
        $rose(in_pd) |-> $past(pd_req) && $past(in_run))
        else $error("power-down entered without request");

    a_pd_priority: assert property (
        in_run && pd_req && idle_req && i_ce && !int_rst
        |=> in_pd)
        else $error("power-down did not win over idle");

    a_wake_zero: assert property (
        in_pd && wake_any && i_ce && !int_rst |=> in_wake && wd_cnt == '0)
        else $error("delay not cleared at wake");

    a_wake_release: assert property (
        in_wake && wd_cnt == WD_W'(WAKE_DLY_CLKS - 1) && i_ce && !int_rst
        |=> in_run && !pd_req)
        else $error("wake delay not 1536 periods");

    a_wake_hold: assert property (
        in_wake |-> !o_cpu_clk_en)
        else $error("cpu clocked during start-up delay");

    a_idle_exit: assert property (
        idle_exit && i_ce && !int_rst |=> in_run && !idle_req)
        else $error("interrupt did not end idle");

    a_reset_hold: assert property (
        rst_sync && rh_cnt == RH_W'(RST_HOLD_CLKS - 1) && i_ce |=> int_rst)
        else $error("reset not taken after 24 periods");

    a_reset_early: assert property (
        !int_rst && rh_cnt < RH_W'(RST_HOLD_CLKS - 1) |=> !int_rst)
        else $error("reset taken too early");

    a_p2_pd_latch: assert property (
        in_pd |-> o_p2_out == i_port_two_latch && o_p2_oe == BYTE_ONES)
        else $error("port 2 not latch in power-down");

    a_p0_float: assert property (
        !in_run && i_ext_mem |-> o_p0_oe == BYTE_ZERO)
        else $error("port 0 driven in low-power mode");
endmodule

// ==== sim/ipc_wake_src.sv ====
// Behavioural reset source and port-1 wake pins facing the mode controller
module ipc_wake_src (
    input  wire logic       i_core_clk,
    input  wire logic       i_osc_run,
    input  wire logic       i_reset_req,
    input  wire logic       i_short,
    input  wire logic [7:0] i_wake_req,
    output logic            o_reset_pin,
    output logic      [7:0] o_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [5:0] hold_cnt = 6'h0;
    logic       req_q    = 1'b0;
    wire        req_rise = i_reset_req & ~req_q;

    // A short pulse is only sent when a scenario asks for a broken source
    always @(posedge i_core_clk) begin
        req_q <= i_reset_req;
        if (req_rise && !i_short) begin
            hold_cnt <= 6'(RST_HOLD_CLKS);
        end else if (hold_cnt != 6'h0 && i_osc_run && !i_reset_req) begin
            // Count only once the oscillator runs again, so it is stable
            hold_cnt <= hold_cnt - 6'h1;
        end
    end

    assign o_reset_pin = i_reset_req | (hold_cnt != 6'h0);
    assign o_wake      = i_wake_req;
endmodule

// ==== sim/ipc_power_ctrl_tb.sv ====
// Self-checking testbench for the idle and power-down controller
module ipc_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ipc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic       clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       bitop = 1'b0, irq = 1'b0, ext_mem = 1'b0, reset_req = 1'b0;
    logic       short_rst = 1'b0, bus_oe = 1'b1, cpu_strb = 1'b1;
    logic [7:0] addr = 8'h87, wdata = 8'h00, wake_req = 8'h00;
    logic [7:0] wake_en = 8'h00, p2_addr = 8'h5a, bus_out = 8'he1;
    logic [7:0] p0_l = 8'h96, p1_l = 8'h3c, p2_l = 8'hc3, p3_l = 8'h69;
    logic       hit, reset_pin, osc, cpu_en, per_en, cpu_rst, tick, baud;
    logic       ale, program_fetch_strobe;
    logic [7:0] rdata, wake, p0_out, p0_oe, p1_out, p2_out, p2_oe, p3_out;
    int         error_cnt = 0;
    int         checked   = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    ipc_power_ctrl ipc_power_ctrl_i (
        .i_core_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_bitop(bitop), .o_sfr_hit(hit),
        .o_sfr_rdata(rdata), .i_reset_pin(reset_pin),
        .i_port1_wake_interrupts(wake), .i_wake_enable(wake_en),
        .i_irq_active(irq), .i_ext_mem(ext_mem), .i_ale_cpu(cpu_strb),
        .i_program_fetch_strobe_cpu(cpu_strb), .i_p0_bus_out(bus_out), .i_p0_bus_oe(bus_oe),
        .i_p2_addr(p2_addr), .i_p0_latch(p0_l), .i_p1_latch(p1_l),
        .i_port_two_latch(p2_l), .i_p3_latch(p3_l), .o_osc_run(osc),
        .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
        .o_cpu_reset(cpu_rst), .o_mcycle_tick(tick), .o_baud_double(baud),
        .o_ale(ale), .o_program_fetch_strobe(program_fetch_strobe), .o_p0_out(p0_out),
        .o_p0_oe(p0_oe), .o_p1_out(p1_out), .o_p2_out(p2_out),
        .o_p2_oe(p2_oe), .o_p3_out(p3_out)
    );

    ipc_wake_src ipc_wake_src_i (
        .i_core_clk(clk), .i_osc_run(osc), .i_reset_req(reset_req),
        .i_short(short_rst), .i_wake_req(wake_req),
        .o_reset_pin(reset_pin), .o_wake(wake)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, d, input logic bop);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        bitop <= bop;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        bitop <= 1'b0;
    endtask

    // Read data lands on the same edge that takes the strobe
    task automatic rd_reg(input logic [7:0] exp);
        @(posedge clk);
        addr <= 8'h87;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        settle(1);
        chk8(rdata, exp);
    endtask

    task automatic count_ticks(input int span, output int n);
        n = 0;
        repeat (span) begin
            settle(1);
            n += int'(tick === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_reg(8'h00);
        chk1(baud, 1'b0);
        chk1(cpu_rst, 1'b0);
        chk8(p0_oe, ~p0_l);
        @(posedge clk);
        ext_mem <= 1'b1;
        settle(1);
        chk8(p0_oe, 8'hff);
        chk8(p0_out, bus_out);
        chk1(ale, 1'b1);
        chk1(program_fetch_strobe, 1'b1);
    endtask

    task automatic t_regs();
        int n;
        wr_reg(8'h87, 8'h8c, 1'b0);
        rd_reg(8'h8c);
        chk1(baud, 1'b1);
        chk1(cpu_en, 1'b1);
        wr_reg(8'h87, 8'h7c, 1'b0);
        rd_reg(8'h0c);
        wr_reg(8'h87, 8'h00, 1'b1);
        rd_reg(8'h0c);
        wr_reg(8'h86, 8'h00, 1'b0);
        rd_reg(8'h0c);
        @(posedge clk);
        bitop <= 1'b1;
        settle(1);
        chk1(hit, 1'b0);
        @(posedge clk);
        bitop <= 1'b0;
        count_ticks(120, n);
        chk1(n == 120 / OSC_PER_MCYCLE, 1'b1);
    endtask

    task automatic t_idle();
        // CPU strobes low so that idle must force them high
        @(posedge clk);
        cpu_strb <= 1'b0;
        wr_reg(8'h87, 8'h0d, 1'b0);
        settle(2);
        chk1(cpu_en, 1'b0);
        chk1(per_en, 1'b1);
        chk1(osc, 1'b1);
        chk1(ale, 1'b1);
        chk1(program_fetch_strobe, 1'b1);
        chk8(p0_oe, 8'h00);
        @(posedge clk);
        p2_addr <= 8'ha5;
        settle(2);
        chk8(p2_out, 8'h5a);
        chk8(p1_out, p1_l);
        // A reset pulse shorter than two machine cycles must not end idle
        @(posedge clk);
        short_rst <= 1'b1;
        reset_req <= 1'b1;
        settle(10);
        @(posedge clk);
        reset_req <= 1'b0;
        settle(8);
        chk1(cpu_en, 1'b0);
        @(posedge clk);
        short_rst <= 1'b0;
        irq <= 1'b1;
        settle(1);
        @(posedge clk);
        irq <= 1'b0;
        settle(3);
        chk1(cpu_en, 1'b1);
        rd_reg(8'h0c);
    endtask

    task automatic t_pd_wake();
        int n;
        logic [7:0] m;
        // CPU strobes high so that power-down must force them low
        @(posedge clk);
        cpu_strb <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            m = 8'h01 << k;
            wr_reg(8'h87, 8'h03, 1'b0);
            settle(2);
            chk1(osc, 1'b0);
            chk1(per_en, 1'b0);
            chk1(ale, 1'b0);
            chk1(program_fetch_strobe, 1'b0);
            chk8(p2_out, p2_l);
            chk8(p2_oe, 8'hff);
            chk8(p0_oe, 8'h00);
            chk8(p1_out, p1_l);
            chk8(p3_out, p3_l);
            // A disabled pin and an interrupt must leave power-down alone
            @(posedge clk);
            wake_en  <= ~m;
            wake_req <= m;
            irq      <= 1'b1;
            count_ticks(20, n);
            chk1(osc, 1'b0);
            chk1(n == 0, 1'b1);
            @(posedge clk);
            irq     <= 1'b0;
            wake_en <= m;
            n = 0;
            while (cpu_en !== 1'b1 && n < 2000) begin
                settle(1);
                n++;
            end
            chk1(n >= WAKE_DLY_CLKS && n <= WAKE_DLY_CLKS + 6, 1'b1);
            @(posedge clk);
            wake_req <= 8'h00;
            wake_en  <= 8'h00;
            rd_reg(8'h00);
        end
    endtask

    task automatic t_rst_wake();
        int n;
        wr_reg(8'h87, 8'h8e, 1'b0);
        settle(2);
        chk1(osc, 1'b0);
        @(posedge clk);
        reset_req <= 1'b1;
        n = 0;
        while (osc !== 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        chk1(n >= RST_HOLD_CLKS && n <= RST_HOLD_CLKS + 8, 1'b1);
        chk1(cpu_rst, 1'b1);
        @(posedge clk);
        reset_req <= 1'b0;
        settle(RST_HOLD_CLKS + 6);
        chk1(cpu_rst, 1'b0);
        rd_reg(8'h00);
        chk1(baud, 1'b0);
        wr_reg(8'h87, 8'h01, 1'b0);
        settle(3);
        chk1(cpu_en, 1'b0);
        @(posedge clk);
        reset_req <= 1'b1;
        settle(1);
        @(posedge clk);
        reset_req <= 1'b0;
        settle(RST_HOLD_CLKS + 8);
        chk1(cpu_en, 1'b1);
        settle(RST_HOLD_CLKS);
        rd_reg(8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The wake loops dominate the run, about 13000 cycles in all
    initial begin
        #(40000 * CLK_PERIOD_NS);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_idle();
        t_pd_wake();
        t_rst_wake();
        complete_run();
    end
endmodule
